// File: hw/lpic_pkg.sv
// constants and types shared by the idle controller
package lpic_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_IDLE_CFG = 8'h00;
	localparam logic [7:0] OFF_IDLE_STATE = 8'h04;
	localparam logic [7:0] OFF_FLAG_LO = 8'h08;
	localparam logic [7:0] OFF_FLAG_HI = 8'h0c;
	localparam logic [7:0] OFF_EN_LO = 8'h10;
	localparam logic [7:0] OFF_EN_HI = 8'h14;
	localparam logic [7:0] OFF_RTC_PMGT = 8'h18;
	localparam logic [7:0] OFF_RTC_INTEN = 8'h1c;
	localparam logic [7:0] OFF_EV_STATUS = 8'h20;
	localparam logic [7:0] OFF_EV_CLEAR = 8'h24;
	localparam logic [7:0] OFF_EV_ENABLE = 8'h28;
	localparam logic [7:0] OFF_POWER_STATE = 8'h2c;

	// idle configuration / state bit positions
	localparam int IDLE_W = 6;
	localparam int IDLE_CPU = 0;
	localparam int IDLE_MEM_PORT = 1;
	localparam int IDLE_XPORT = 2;
	localparam int IDLE_DPORT = 3;
	localparam int IDLE_IPORT = 4;
	localparam int IDLE_CACHE = 5;
	localparam logic [5:0] IDLE_RST = 6'h00;
	localparam logic [5:0] CLK_EN_RST = 6'h3f;

	// interrupt flag layout
	localparam int FLAG_W = 16;
	localparam logic [15:0] EXT_A_MASK = 16'h0004;
	localparam logic [15:0] EXT_B_MASK = 16'h0008;
	localparam logic [15:0] RTC_MASK = 16'h0004;
	localparam int RTC_BIT = 2;
	localparam logic [15:0] FLAG_RST = 16'h0000;

	// single-bit fields and power state layout
	localparam int WAKE_DIR_BIT = 0;
	localparam int RTC_INTEN_BIT = 0;
	localparam int PSTATE_BLK_BIT = 2;

	// controller events
	localparam int EV_W = 3;
	localparam int EV_WAKE = 0;
	localparam int EV_REFUSE = 1;
	localparam int EV_ENTER = 2;
	localparam logic [2:0] EV_RST = 3'h0;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {MODE_ACTIVE, MODE_LIGHT, MODE_DEEP} lpic_mode_t;

	typedef struct packed {
		logic wake;
	} lpic_wake_st_t;

	typedef struct packed {
		logic [5:0] idle_cfg;
		logic [5:0] idle_st;
		logic [5:0] clk_en;
		logic [15:0] flag_lo;
		logic [15:0] flag_hi;
		logic [15:0] en_lo;
		logic [15:0] en_hi;
		logic wake_dir;
		logic rtc_en;
		logic [2:0] ev_status;
		logic [2:0] ev_enable;
		lpic_mode_t mode;
		logic cpu_wake;
		logic mem_port_blk;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} lpic_ctrl_st_t;

endpackage

// File: hw/lpic_wake.sv
// wake request combiner for the idle controller
`timescale 1ns/1ps
module lpic_wake
	import lpic_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pending flags and their enables
	input wire logic [15:0] flag_lo,
	input wire logic [15:0] flag_hi,
	input wire logic [15:0] en_lo,
	input wire logic [15:0] en_hi,
	// wake pin
	input wire logic wake_pin,
	input wire logic wake_dir,
	// combined request
	output logic wake
);
	lpic_wake_st_t st;
	lpic_wake_st_t next_st;

	// pin counts only when configured as input
	always_comb
	begin
		next_st = st;
		next_st.wake = (|(flag_lo & en_lo)) || (|(flag_hi & en_hi)) ||
			(wake_pin && wake_dir);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign wake = st.wake;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	pin_wake_a: assert property (wake_pin && wake_dir |=> wake)
		else $error("wake pin as input did not raise wake");
	flag_wake_a: assert property (!(|(flag_lo & en_lo)) &&
		!(|(flag_hi & en_hi)) && !(wake_pin && wake_dir) |=> !wake)
		else $error("wake raised with no enabled source");
endmodule

// File: hw/lpic_ctrl.sv
// low power idle controller with axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module lpic_ctrl
	import lpic_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// cpu side
	input wire logic idle_exec,
	output logic cpu_wake,
	// bus masters that hold the memory port
	input wire logic usb_dma_active,
	input wire logic lcd_active,
	input wire logic dma_active,
	// wake sources
	input wire logic wake_pin,
	input wire logic rtc_event,
	input wire logic ext_irq_a,
	input wire logic ext_irq_b,
	input wire logic [15:0] periph_irq_lo,
	input wire logic [15:0] periph_irq_hi,
	// clock generator status
	input wire logic clkgen_enabled,
	// clock gating and mode outputs
	output logic [5:0] domain_clk_en,
	output logic periph_clk_stop,
	output logic clkgen_run,
	output logic light_sleep,
	output logic deep_sleep,
	// interrupt
	output logic irq
);
	lpic_ctrl_st_t st;
	lpic_ctrl_st_t next_st;

	logic aw_take;
	logic w_take;
	logic aw_now;
	logic w_now;
	logic wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [31:0] wr_mask;
	logic [31:0] wr_bits;
	logic [31:0] rd_word;
	logic [15:0] set_lo;
	logic [15:0] set_hi;
	logic [15:0] clr_lo;
	logic [15:0] clr_hi;
	logic [2:0] ev_set;
	logic [2:0] ev_clr;
	logic rtc_set;
	logic masters_idle;
	logic blk;
	logic wake;
	logic sleeping;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'h0) && (a <= OFF_POWER_STATE);
	endfunction

	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	lpic_wake u_wake (
		.aclk(aclk),
		.aresetn(aresetn),
		.flag_lo(st.flag_lo),
		.flag_hi(st.flag_hi),
		.en_lo(st.en_lo),
		.en_hi(st.en_hi),
		.wake_pin(wake_pin),
		.wake_dir(st.wake_dir),
		.wake(wake)
	);

	// address and data may arrive in either order
	assign awready = !st.aw_got && !st.bvalid;
	assign wready = !st.w_got && !st.bvalid;
	assign arready = !st.rvalid;
	assign aw_take = awvalid && awready;
	assign w_take = wvalid && wready;
	assign aw_now = st.aw_got || aw_take;
	assign w_now = st.w_got || w_take;
	assign wr_fire = aw_now && w_now;
	assign wr_addr = st.aw_got ? st.awaddr : awaddr;
	assign wr_data = st.w_got ? st.wdata : wdata;
	assign wr_mask = strb_mask(st.w_got ? st.wstrb : wstrb);
	assign wr_bits = wr_data & wr_mask;

	// rtc bit also carries the wake pin
	assign rtc_set = (rtc_event && st.rtc_en) ||
		(wake_pin && st.wake_dir);
	assign set_lo = periph_irq_lo | (EXT_A_MASK & {FLAG_W{ext_irq_a}}) |
		(EXT_B_MASK & {FLAG_W{ext_irq_b}});
	assign set_hi = (periph_irq_hi & ~RTC_MASK) |
		(RTC_MASK & {FLAG_W{rtc_set}});
	assign clr_lo = (wr_fire && wr_addr == OFF_FLAG_LO) ?
		wr_bits[15:0] : FLAG_RST;
	assign clr_hi = (wr_fire && wr_addr == OFF_FLAG_HI) ?
		wr_bits[15:0] : FLAG_RST;
	assign ev_clr = (wr_fire && wr_addr == OFF_EV_CLEAR) ?
		wr_bits[2:0] : EV_RST;

	assign masters_idle = !(usb_dma_active || lcd_active || dma_active);
	assign blk = st.idle_st[IDLE_MEM_PORT] && !masters_idle;
	assign sleeping = (st.mode != MODE_ACTIVE);
	assign ev_set[EV_WAKE] = sleeping && wake;
	assign ev_set[EV_REFUSE] = blk && !st.mem_port_blk;
	assign ev_set[EV_ENTER] = !sleeping && idle_exec &&
		st.idle_cfg[IDLE_CPU];

	always_comb
	begin
		next_st = st;
		next_st.cpu_wake = 1'b0;
		rd_word = '0;
		unique case (araddr)
			OFF_IDLE_CFG: rd_word[5:0] = st.idle_cfg;
			OFF_IDLE_STATE: rd_word[5:0] = st.idle_st;
			OFF_FLAG_LO: rd_word[15:0] = st.flag_lo;
			OFF_FLAG_HI: rd_word[15:0] = st.flag_hi;
			OFF_EN_LO: rd_word[15:0] = st.en_lo;
			OFF_EN_HI: rd_word[15:0] = st.en_hi;
			OFF_RTC_PMGT: rd_word[WAKE_DIR_BIT] = st.wake_dir;
			OFF_RTC_INTEN: rd_word[RTC_INTEN_BIT] = st.rtc_en;
			OFF_EV_STATUS: rd_word[2:0] = st.ev_status;
			OFF_EV_ENABLE: rd_word[2:0] = st.ev_enable;
			OFF_POWER_STATE:
			begin
				rd_word[1:0] = st.mode;
				rd_word[PSTATE_BLK_BIT] = st.mem_port_blk;
			end
			default: rd_word = '0;
		endcase

		// write channels
		if (wr_fire)
		begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
			case (wr_addr)
				OFF_IDLE_CFG: next_st.idle_cfg =
					(st.idle_cfg & ~wr_mask[5:0]) | wr_bits[5:0];
				OFF_EN_LO: next_st.en_lo =
					(st.en_lo & ~wr_mask[15:0]) | wr_bits[15:0];
				OFF_EN_HI: next_st.en_hi =
					(st.en_hi & ~wr_mask[15:0]) | wr_bits[15:0];
				OFF_RTC_PMGT: if (wr_mask[WAKE_DIR_BIT])
					next_st.wake_dir = wr_data[WAKE_DIR_BIT];
				OFF_RTC_INTEN: if (wr_mask[RTC_INTEN_BIT])
					next_st.rtc_en = wr_data[RTC_INTEN_BIT];
				OFF_EV_ENABLE: next_st.ev_enable =
					(st.ev_enable & ~wr_mask[2:0]) | wr_bits[2:0];
				default: next_st.bresp = next_st.bresp;
			endcase
		end
		else
		begin
			if (aw_take)
			begin
				next_st.aw_got = 1'b1;
				next_st.awaddr = awaddr;
			end
			if (w_take)
			begin
				next_st.w_got = 1'b1;
				next_st.wdata = wdata;
				next_st.wstrb = wstrb;
			end
		end
		if (st.bvalid && bready)
			next_st.bvalid = 1'b0;

		// read channels
		if (arvalid && arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_word;
			next_st.rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (st.rvalid && rready)
			next_st.rvalid = 1'b0;

		// set wins over a clear in the same cycle
		next_st.flag_lo = (st.flag_lo & ~clr_lo) | set_lo;
		next_st.flag_hi = (st.flag_hi & ~clr_hi) | set_hi;
		next_st.ev_status = (st.ev_status & ~ev_clr) | ev_set;
		next_st.mem_port_blk = blk;

		unique case (st.mode)
			MODE_ACTIVE:
				if (idle_exec)
				begin
					next_st.idle_st = st.idle_cfg;
					if (st.idle_cfg[IDLE_CPU])
						next_st.mode = clkgen_enabled ?
							MODE_LIGHT : MODE_DEEP;
				end
			MODE_LIGHT, MODE_DEEP:
				if (wake)
				begin
					// all idle state bits drop so clocks run before the fetch
					next_st.idle_st = IDLE_RST;
					next_st.mode = MODE_ACTIVE;
					next_st.cpu_wake = 1'b1;
				end
		endcase

		// memory port idles only once every master has let go
		next_st.clk_en = ~next_st.idle_st;
		next_st.clk_en[IDLE_MEM_PORT] =
			!(next_st.idle_st[IDLE_MEM_PORT] && masters_idle);
	end

	// synchronous reset discards everything held before idle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.clk_en <= CLK_EN_RST;
			st.mode <= MODE_ACTIVE;
		end
		else
			st <= next_st;
	end

	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign cpu_wake = st.cpu_wake;
	assign domain_clk_en = st.clk_en;
	assign periph_clk_stop = sleeping;
	assign clkgen_run = (st.mode != MODE_DEEP);
	assign light_sleep = (st.mode == MODE_LIGHT);
	assign deep_sleep = (st.mode == MODE_DEEP);
	assign irq = |(st.ev_status & st.ev_enable);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	idle_copy_a: assert property (st.mode == MODE_ACTIVE && idle_exec
		|=> st.idle_st == $past(st.idle_cfg))
		else $error("idle state did not take the idle config");
	cpu_gate_a: assert property (domain_clk_en[IDLE_CPU] ==
		!st.idle_st[IDLE_CPU])
		else $error("cpu clock enable disagrees with idle state");
	port_busy_a: assert property (!masters_idle
		|=> domain_clk_en[IDLE_MEM_PORT])
		else $error("memory port gated while a master is busy");
	flag_clear_a: assert property (wr_fire && wr_addr == OFF_FLAG_LO &&
		periph_irq_lo == FLAG_RST && !ext_irq_a && !ext_irq_b
		|=> (st.flag_lo & $past(wr_bits[15:0])) == FLAG_RST)
		else $error("write one did not clear a flag");
	rtc_gate_a: assert property (!st.rtc_en && !wake_pin &&
		!st.flag_hi[RTC_BIT] && !clr_hi[RTC_BIT] |=> !st.flag_hi[RTC_BIT])
		else $error("rtc flag set while rtc interrupt disabled");
	pin_exit_a: assert property (sleeping && wake_pin && st.wake_dir
		|-> ##[1:2] cpu_wake)
		else $error("wake pin did not wake the cpu");
	flag_exit_a: assert property (sleeping &&
		(|(st.flag_lo & st.en_lo)) |-> ##[1:2] cpu_wake)
		else $error("enabled flag did not wake the cpu");
	wake_restart_a: assert property (cpu_wake |-> st.mode ==
		MODE_ACTIVE && st.idle_st == IDLE_RST && domain_clk_en[IDLE_CPU])
		else $error("cpu woke with its clocks still gated");
	reset_exit_a: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> st.mode == MODE_ACTIVE && st.idle_st == IDLE_RST && !irq)
		else $error("reset did not clear the idle state");
	light_clk_a: assert property (light_sleep |-> clkgen_run &&
		periph_clk_stop && !domain_clk_en[IDLE_CPU])
		else $error("light sleep clock states wrong");

	light_entry_c: cover property (st.mode == MODE_ACTIVE ##1 light_sleep);
	deep_entry_c: cover property (st.mode == MODE_ACTIVE ##1 deep_sleep);
	wake_light_c: cover property (light_sleep ##1 cpu_wake);
	port_held_c: cover property (st.idle_st[IDLE_MEM_PORT] &&
		st.mem_port_blk);
endmodule

// File: verif/lpic_wake_src.sv
// wake source and idle issue model for the idle controller bench
`timescale 1ns/1ps
module lpic_wake_src
	import lpic_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// commands from the bench
	input wire logic idle_req,
	input wire logic fire,
	input wire logic [1:0] sel,
	input wire logic [3:0] lag,
	// idle pulse and wake requests: pin, rtc, ext a, ext b
	output logic idle_exec,
	output logic [3:0] src
);
	logic [3:0] cnt;
	logic [1:0] which;
	logic pend;
	// no core voltage steps here, so clock limits hold
	always_ff @(posedge aclk)
	begin
		idle_exec <= idle_req && aresetn; // copy of idle_req, one cycle later
		src <= 4'h0;
		if (!aresetn)
			pend <= 1'b0;
		else if (fire)
		begin
			pend <= 1'b1;
			cnt <= lag;
			which <= sel;
		end
		else if (pend && cnt != 4'h0)
			cnt <= cnt - 4'h1;
		else if (pend)
		begin
			pend <= 1'b0;
			src[which] <= 1'b1;
		end
	end
endmodule

// File: verif/low_power_idle_controller_tb.sv
// self-checking bench for the low power idle controller
`timescale 1ns/1ps
module low_power_idle_controller_tb
	import lpic_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [2:0] busy = 3'h0;
	logic clkgen_enabled = 1'b1;
	logic [15:0] pirq = 16'h0;
	logic idle_req = 1'b0;
	logic fire = 1'b0;
	logic [1:0] sel = 2'h0;
	logic [3:0] lag = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, idle_exec, cpu_wake;
	logic periph_clk_stop, clkgen_run, light_sleep, deep_sleep, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [5:0] domain_clk_en;
	logic [3:0] src;
	int fail_count = 0;
	int n_checks = 0;

	always #25 aclk = ~aclk;

	lpic_ctrl dut_u (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.idle_exec(idle_exec), .cpu_wake(cpu_wake),
		.usb_dma_active(busy[0]), .lcd_active(busy[1]), .dma_active(busy[2]),
		.wake_pin(src[0]), .rtc_event(src[1]), .ext_irq_a(src[2]),
		.ext_irq_b(src[3]), .periph_irq_lo(pirq), .periph_irq_hi(16'h0000),
		.clkgen_enabled(clkgen_enabled), .domain_clk_en(domain_clk_en),
		.periph_clk_stop(periph_clk_stop), .clkgen_run(clkgen_run),
		.light_sleep(light_sleep), .deep_sleep(deep_sleep), .irq(irq)
	);
	lpic_wake_src wsrc_u (
		.aclk(aclk), .aresetn(aresetn), .idle_req(idle_req), .fire(fire),
		.sel(sel), .lag(lag), .idle_exec(idle_exec), .src(src)
	);

	task conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, x, g);
		end
	endtask

	// sleep flags then clock enables, as one word
	task so(input logic [9:0] x);
		chk("modes", {22'h0, x}, {22'h0, light_sleep, deep_sleep,
			clkgen_run, periph_clk_stop, domain_clk_en});
	endtask

	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// one axi4-lite transfer; for reads d is the expected data
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] xr);
		logic done;
		done = 1'b0;
		cyc(1);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= w;
		wvalid <= w;
		bready <= w;
		arvalid <= !w;
		rready <= !w;
		for (int k = 0; k < 40 && !done; k++)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
			if ((bvalid && w) || (rvalid && !w))
			begin
				done = 1'b1;
				bready <= 1'b0;
				rready <= 1'b0;
				chk("resp", {30'h0, xr}, {30'h0, w ? bresp : rresp});
				if (!w) chk("rdata", d, rdata);
			end
		end
		if (!done)
		begin
			chk("handshake", 32'h1, 32'h0);
			conclude();
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, RESP_OKAY);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] d);
		bus(1'b0, a, d, RESP_OKAY);
	endtask

	task slp;
		cyc(1);
		idle_req <= 1'b1;
		cyc(1);
		idle_req <= 1'b0;
		cyc(2);
	endtask

	task fw(input logic [1:0] s, input logic [3:0] l);
		cyc(1);
		fire <= 1'b1;
		sel <= s;
		lag <= l;
		cyc(1);
		fire <= 1'b0;
	endtask

	// bounded wait for the wake pulse, or its absence
	task ww(input int n, input logic xw);
		logic seen;
		seen = 1'b0;
		for (int k = 0; k < n && !seen; k++)
		begin
			@(posedge aclk);
			seen = cpu_wake;
		end
		chk("cpu_wake", {31'h0, xw}, {31'h0, seen});
		if (xw && !seen)
			conclude();
	endtask

	initial
	begin
		cyc(8);
		aresetn <= 1'b1;
		cyc(1);
		so(10'h0bf);
		rd(OFF_IDLE_STATE, 32'h0);
		wr(OFF_IDLE_CFG, 32'hffffffff);
		rd(OFF_IDLE_CFG, 32'h3f);
		bus(1'b1, 8'h30, 32'h1, RESP_SLVERR);
		bus(1'b0, 8'h30, 32'h0, RESP_SLVERR);
		wr(OFF_IDLE_STATE, 32'h3f);
		rd(OFF_IDLE_STATE, 32'h0);
		$display("test registers over");
		fw(2'h3, 4'h0);
		pirq <= 16'h0020;
		cyc(1);
		pirq <= 16'h0;
		cyc(4);
		rd(OFF_FLAG_LO, 32'h28);
		wr(OFF_FLAG_LO, 32'h20);
		rd(OFF_FLAG_LO, 32'h08);
		wr(OFF_FLAG_LO, 32'h08);
		rd(OFF_FLAG_LO, 32'h0);
		$display("test flags over");
		busy <= 3'h0;
		wr(OFF_RTC_PMGT, 32'h1);
		wr(OFF_EV_ENABLE, 32'h4);
		slp();
		so(10'h2c0);
		rd(OFF_IDLE_STATE, 32'h3f);
		rd(OFF_POWER_STATE, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFF_EV_CLEAR, 32'h4);
		cyc(2);
		chk("irq", 32'h0, {31'h0, irq});
		fw(2'h0, 4'h9);
		ww(40, 1'b1);
		so(10'h0bf);
		rd(OFF_IDLE_STATE, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(OFF_FLAG_HI, 32'h4);
		wr(OFF_EV_CLEAR, 32'h7);
		$display("test light sleep over");
		wr(OFF_RTC_PMGT, 32'h0);
		slp();
		fw(2'h0, 4'h0);
		ww(12, 1'b0);
		fw(2'h1, 4'h0);
		ww(12, 1'b0);
		wr(OFF_RTC_INTEN, 32'h1);
		wr(OFF_EN_HI, 32'h4);
		fw(2'h1, 4'h0);
		ww(30, 1'b1);
		wr(OFF_FLAG_HI, 32'h4);
		$display("test wake gating over");
		wr(OFF_EN_LO, 32'h4);
		busy <= 3'h4;
		clkgen_enabled <= 1'b0;
		wr(OFF_FLAG_LO, 32'hffff);
		slp();
		so(10'h142);
		rd(OFF_POWER_STATE, 32'h6);
		rd(OFF_EV_STATUS, 32'h7);
		for (int i = 0; i < 3; i++)
		begin
			busy <= 3'h1 << i;
			cyc(3);
			so(10'h142);
		end
		busy <= 3'h0;
		cyc(3);
		so(10'h140);
		fw(2'h2, 4'h0);
		ww(30, 1'b1);
		so(10'h0bf);
		clkgen_enabled <= 1'b1;
		wr(OFF_FLAG_LO, 32'h4);
		$display("test deep sleep over");
		wr(OFF_IDLE_CFG, 32'h3e);
		slp();
		so(10'h081);
		wr(OFF_IDLE_CFG, 32'h3f);
		slp();
		so(10'h2c0);
		aresetn <= 1'b0;
		cyc(2);
		aresetn <= 1'b1;
		cyc(1);
		so(10'h0bf);
		rd(OFF_IDLE_CFG, 32'h0);
		rd(OFF_EN_LO, 32'h0);
		$display("test reset exit over");
		conclude();
	end
endmodule
